// ### logic/cmds_pkg.sv
// Constants, types and helpers for the clock mode and divider selector.
// Assumes one system clock; PLL and reference clocks arrive as one-cycle ticks.
package cmds_pkg;

  // Register byte offsets
  localparam logic [7:0] CMDS_OFS_STATUS = 8'h00;
  localparam logic [7:0] CMDS_OFS_DIV = 8'h04;
  localparam logic [7:0] CMDS_OFS_GATE = 8'h08;

  // Field positions in the status register
  localparam int CMDS_STAT_MODE_LSB = 0;
  localparam int CMDS_STAT_ACT_LSB = 3;
  localparam int CMDS_STAT_PEND_BIT = 6;

  // Gate register field positions and width
  localparam int CMDS_GATE_W = 12;
  localparam int CMDS_GATE_PROC_LSB = 0;
  localparam int CMDS_GATE_SP_LSB = 4;
  localparam int CMDS_GATE_TC_LSB = 8;
  localparam int CMDS_SUB_N = 4;

  // Reset values
  localparam logic [7:0] CMDS_DIV_RST = 8'h00;
  localparam logic [11:0] CMDS_GATE_RST = 12'hfff;

  // Phase counter of the PLL tick stream
  localparam int CMDS_CNT_W = 3;
  localparam logic [2:0] CMDS_CNT_MAX = 3'h7;

  typedef enum logic [2:0] {
    CMDS_FULL_SYNC = 3'b000,
    CMDS_RSV_1 = 3'b001,
    CMDS_SCALABLE = 3'b010,
    CMDS_RSV_3 = 3'b011,
    CMDS_RSV_4 = 3'b100,
    CMDS_BYPASS = 3'b101,
    CMDS_MIX3 = 3'b110,
    CMDS_MIX4 = 3'b111
  } cmds_mode_e;

  // Divide-down fields: 0..3 means divide by 1, 2, 4, 8
  typedef struct packed {
    logic [1:0] tc;
    logic [1:0] spmmu;
    logic [1:0] sp;
    logic [1:0] proc;
  } cmds_div_s;

  function automatic logic cmds_is_reserved(input logic [2:0] code);
    cmds_is_reserved = (code == CMDS_RSV_1) || (code == CMDS_RSV_3) || (code == CMDS_RSV_4);
  endfunction

  // Tick of a domain divided from the PLL tick stream, aligned on the phase counter
  function automatic logic cmds_tick(input logic pll, input logic [2:0] cnt,
                                     input logic [1:0] div);
    logic [2:0] mask;
    mask = 3'h0;
    case (div)
      2'h0: mask = 3'h0;
      2'h1: mask = 3'h1;
      2'h2: mask = 3'h3;
      default: mask = 3'h7;
    endcase
    cmds_tick = pll && ((cnt & mask) == 3'h0);
  endfunction

endpackage

// ### logic/cmds_top.sv
// Clock mode and divide-down selector with a classic Wishbone register slave.
// Assumes PLL output and reference clock come in as one-cycle ticks of i_clk;
// domain clocks leave as one-cycle enable pulses.
//
// How it works
// - Domain clocks divided from primary PLL ticks
// - Reference clock tick comes from low-power source
// - Subdomain enables gated independently by gate register
// - Three-bit mode field resets to full sync
// - Mode 000 uses one ratio for all
// - Mode 010 keeps domains phase aligned, multiples
// - Scalable mode: each divider sets own domain
// - Reserved mode codes written are ignored
// - Mix modes share one ratio: tc with proc in mode 110, spmmu and tc with sp in mode 111
// - Mix three: processor with traffic, sp scaled
// - Mode 101 feeds reference tick to all
`timescale 1ns/10ps
module cmds_top (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_rst_n,
  // Clock sources
  input wire logic i_pll_tick,
  input wire logic i_ref_tick,
  // Wishbone slave
  input wire logic i_wb_cyc,
  input wire logic i_wb_stb,
  input wire logic i_wb_we,
  input wire logic [7:0] i_wb_adr,
  input wire logic [3:0] i_wb_sel,
  input wire logic [31:0] i_wb_dat,
  output logic o_wb_ack,
  output logic [31:0] o_wb_dat,
  // Domain clock enables
  output logic o_proc_clk_en,
  output logic o_sp_clk_en,
  output logic o_spmmu_clk_en,
  output logic o_tc_clk_en,
  // Subdomain clock enables
  output logic [3:0] o_proc_sub_clk_en,
  output logic [3:0] o_sp_sub_clk_en,
  output logic [3:0] o_tc_sub_clk_en
);

  logic [2:0] mode_q;
  logic [2:0] act_mode_q;
  cmds_pkg::cmds_div_s div_q;
  cmds_pkg::cmds_div_s act_div_q;
  logic [11:0] gate_q;
  logic [2:0] cnt_q;
  logic ack_q;
  logic [31:0] dat_q;
  logic req;
  logic wr_commit;
  logic pending;
  logic boundary;
  logic proc_tick;
  logic sp_tick;
  logic spmmu_tick;
  logic tc_tick;
  logic [1:0] proc_div;
  logic [1:0] sp_div;
  logic [1:0] spmmu_div;
  logic [1:0] tc_div;

  assign req = i_wb_cyc && i_wb_stb;
  // Write commits at the edge where the master sees ack
  assign wr_commit = req && i_wb_we && ack_q;
  assign pending = (mode_q != act_mode_q) || (div_q != act_div_q);

  // Wishbone acknowledge, one cycle after request
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      ack_q <= 1'b0;
    end else begin
      ack_q <= req && !ack_q;
    end
  end

  // Read data captured with the request
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      dat_q <= 32'h0;
    end else if (req && !ack_q) begin
      if (i_wb_adr == cmds_pkg::CMDS_OFS_STATUS) begin
        dat_q <= 32'h0;
        dat_q[cmds_pkg::CMDS_STAT_MODE_LSB +: 3] <= mode_q;
        dat_q[cmds_pkg::CMDS_STAT_ACT_LSB +: 3] <= act_mode_q;
        dat_q[cmds_pkg::CMDS_STAT_PEND_BIT] <= pending;
      end else if (i_wb_adr == cmds_pkg::CMDS_OFS_DIV) begin
        dat_q <= {24'h0, div_q};
      end else if (i_wb_adr == cmds_pkg::CMDS_OFS_GATE) begin
        dat_q <= {20'h0, gate_q};
      end else begin
        dat_q <= 32'h0;
      end
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      mode_q <= cmds_pkg::CMDS_FULL_SYNC;
    end else if (wr_commit && i_wb_sel[0] && (i_wb_adr == cmds_pkg::CMDS_OFS_STATUS)) begin
      if (!cmds_pkg::cmds_is_reserved(i_wb_dat[cmds_pkg::CMDS_STAT_MODE_LSB +: 3])) begin
        mode_q <= i_wb_dat[cmds_pkg::CMDS_STAT_MODE_LSB +: 3];
      end
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      div_q <= cmds_pkg::CMDS_DIV_RST;
    end else if (wr_commit && i_wb_sel[0] && (i_wb_adr == cmds_pkg::CMDS_OFS_DIV)) begin
      div_q <= i_wb_dat[7:0];
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      gate_q <= cmds_pkg::CMDS_GATE_RST;
    end else if (wr_commit && (i_wb_adr == cmds_pkg::CMDS_OFS_GATE)) begin
      if (i_wb_sel[0]) begin
        gate_q[7:0] <= i_wb_dat[7:0];
      end
      if (i_wb_sel[1]) begin
        gate_q[11:8] <= i_wb_dat[11:8];
      end
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      cnt_q <= 3'h0;
    end else if (i_pll_tick) begin
      cnt_q <= cnt_q + 3'h1;
    end
  end

  // boundary where all divided clocks align
  always_comb begin
    if (act_mode_q == cmds_pkg::CMDS_BYPASS) begin
      boundary = i_ref_tick;
    end else begin
      boundary = i_pll_tick && (cnt_q == cmds_pkg::CMDS_CNT_MAX);
    end
  end

  // settings taken over only at boundary
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      act_mode_q <= cmds_pkg::CMDS_FULL_SYNC;
      act_div_q <= cmds_pkg::CMDS_DIV_RST;
    end else if (boundary) begin
      act_mode_q <= mode_q;
      act_div_q <= div_q;
    end
  end

  // Effective ratio per domain from the active mode
  always_comb begin
    proc_div = act_div_q.proc;
    sp_div = act_div_q.sp;
    spmmu_div = act_div_q.spmmu;
    tc_div = act_div_q.tc;
    case (act_mode_q)
      cmds_pkg::CMDS_FULL_SYNC: begin
        sp_div = act_div_q.proc;
        spmmu_div = act_div_q.proc;
        tc_div = act_div_q.proc;
      end
      cmds_pkg::CMDS_MIX3: begin
        tc_div = act_div_q.proc;
      end
      cmds_pkg::CMDS_MIX4: begin
        spmmu_div = act_div_q.sp;
        tc_div = act_div_q.sp;
      end
      default: begin
        proc_div = act_div_q.proc;
      end
    endcase
  end

  // ticks aligned on one phase counter
  always_comb begin
    if (act_mode_q == cmds_pkg::CMDS_BYPASS) begin
      proc_tick = i_ref_tick;
      sp_tick = i_ref_tick;
      spmmu_tick = i_ref_tick;
      tc_tick = i_ref_tick;
    end else begin
      proc_tick = cmds_pkg::cmds_tick(i_pll_tick, cnt_q, proc_div);
      sp_tick = cmds_pkg::cmds_tick(i_pll_tick, cnt_q, sp_div);
      spmmu_tick = cmds_pkg::cmds_tick(i_pll_tick, cnt_q, spmmu_div);
      tc_tick = cmds_pkg::cmds_tick(i_pll_tick, cnt_q, tc_div);
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      o_proc_clk_en <= 1'b0;
      o_sp_clk_en <= 1'b0;
      o_spmmu_clk_en <= 1'b0;
      o_tc_clk_en <= 1'b0;
    end else begin
      o_proc_clk_en <= proc_tick;
      o_sp_clk_en <= sp_tick;
      o_spmmu_clk_en <= spmmu_tick;
      o_tc_clk_en <= tc_tick;
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      o_proc_sub_clk_en <= 4'h0;
      o_sp_sub_clk_en <= 4'h0;
      o_tc_sub_clk_en <= 4'h0;
    end else begin
      o_proc_sub_clk_en <= {4{proc_tick}} &
        gate_q[cmds_pkg::CMDS_GATE_PROC_LSB +: cmds_pkg::CMDS_SUB_N];
      o_sp_sub_clk_en <= {4{sp_tick}} & gate_q[cmds_pkg::CMDS_GATE_SP_LSB +: cmds_pkg::CMDS_SUB_N];
      o_tc_sub_clk_en <= {4{tc_tick}} & gate_q[cmds_pkg::CMDS_GATE_TC_LSB +: cmds_pkg::CMDS_SUB_N];
    end
  end

  assign o_wb_ack = ack_q;
  assign o_wb_dat = dat_q;

  // Write of a reserved code to the status register
  sequence seq_wr_reserved;
    wr_commit && i_wb_sel[0] && (i_wb_adr == cmds_pkg::CMDS_OFS_STATUS) &&
      cmds_pkg::cmds_is_reserved(i_wb_dat[2:0]);
  endsequence

  // Request held through to its acknowledge
  sequence seq_req_ack;
    (req && !ack_q) ##1 (req && ack_q);
  endsequence

  AST_RESET_MODE: assert property (@(posedge i_clk)
    !$past(i_rst_n) && i_rst_n |-> (mode_q == 3'b000) && (act_mode_q == 3'b000))
    else $error("Mode not full sync after reset");

  AST_FULL_SYNC_EQUAL: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (act_mode_q == 3'b000) |-> ##1 (o_proc_clk_en == o_sp_clk_en) &&
      (o_sp_clk_en == o_tc_clk_en) && (o_tc_clk_en == o_spmmu_clk_en))
    else $error("Domain enables differ in full sync mode");

  AST_RESERVED_IGNORED: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    seq_wr_reserved |=> $stable(mode_q))
    else $error("Reserved mode code was accepted");

  AST_BYPASS_REF: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (act_mode_q == 3'b101) |=> (o_proc_clk_en == $past(i_ref_tick)) &&
      (o_tc_clk_en == $past(i_ref_tick)) && (o_sp_clk_en == $past(i_ref_tick)))
    else $error("Bypass mode does not pass reference tick");

  AST_MIX3_PAIR: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (act_mode_q == 3'b110) |=> (o_proc_clk_en == o_tc_clk_en))
    else $error("Processor and traffic enables differ in mix three");

  AST_MIX4_PAIR: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (act_mode_q == 3'b111) |=> (o_sp_clk_en == o_tc_clk_en) && (o_sp_clk_en == o_spmmu_clk_en))
    else $error("Sp and traffic enables differ in mix four");

  AST_PLL_SOURCE: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (act_mode_q != 3'b101) && !i_pll_tick |=> !o_proc_clk_en && !o_sp_clk_en && !o_tc_clk_en)
    else $error("Domain enable without a PLL tick");

  AST_SCALABLE_RATIO: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (act_mode_q == 3'b010) && i_pll_tick && (cnt_q == 3'h4) |=>
      (o_proc_clk_en == (act_div_q.proc != 2'h3)) && (o_tc_clk_en == (act_div_q.tc != 2'h3)))
    else $error("Scalable divider ratio not applied");

  AST_SWITCH_AT_BOUNDARY: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    $past(i_rst_n) && (act_div_q != $past(act_div_q)) |-> $past(boundary))
    else $error("Divider switched away from phase boundary");

  AST_GATE_OFF: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    !gate_q[0] ##1 !gate_q[0] |-> !o_proc_sub_clk_en[0])
    else $error("Gated subdomain enable pulsed");

  AST_WB_ACK: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    seq_req_ack |=> !o_wb_ack)
    else $error("Ack not dropped after one cycle");

  AST_RESET_OUTPUTS: assert property (@(posedge i_clk)
    !$past(i_rst_n) && i_rst_n |-> !o_wb_ack && !o_proc_clk_en && !o_sp_clk_en &&
      !o_spmmu_clk_en && !o_tc_clk_en && (o_tc_sub_clk_en == 4'h0))
    else $error("Outputs not idle after reset");

  AST_ACK_NEXT: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    req && !ack_q |=> o_wb_ack)
    else $error("Request not acknowledged in one cycle");

  AST_FULL_SYNC_RATIO: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (act_mode_q == 3'b000) && i_pll_tick && (cnt_q == 3'h4) |=>
      (o_tc_clk_en == (act_div_q.proc != 2'h3)) && (o_sp_clk_en == (act_div_q.proc != 2'h3)))
    else $error("Full sync mode does not use the processor divider");

  AST_SCALABLE_SP: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (act_mode_q == 3'b010) && i_pll_tick && (cnt_q == 3'h2) |=>
      (o_sp_clk_en == (act_div_q.sp < 2'h2)) && (o_spmmu_clk_en == (act_div_q.spmmu < 2'h2)))
    else $error("Scalable sp or mmu ratio not applied");

  AST_MIX3_SP_OWN: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (act_mode_q == 3'b110) && i_pll_tick && (cnt_q == 3'h2) |=>
      (o_sp_clk_en == (act_div_q.sp < 2'h2)) && (o_tc_clk_en == (act_div_q.proc < 2'h2)))
    else $error("Mix three ratios not applied");

  AST_MIX4_PROC_OWN: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (act_mode_q == 3'b111) && i_pll_tick && (cnt_q == 3'h2) |=>
      (o_proc_clk_en == (act_div_q.proc < 2'h2)) && (o_tc_clk_en == (act_div_q.sp < 2'h2)))
    else $error("Mix four ratios not applied");

  AST_MODE_AT_BOUNDARY: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    $past(i_rst_n) && (act_mode_q != $past(act_mode_q)) |-> $past(boundary))
    else $error("Mode switched away from phase boundary");

  AST_REF_ONLY: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (act_mode_q == 3'b101) && !i_ref_tick |=>
      !o_proc_clk_en && !o_spmmu_clk_en && !o_tc_clk_en)
    else $error("Bypass enable without a reference tick");

  AST_SUB_WITH_DOMAIN: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (o_sp_sub_clk_en != 4'h0) |-> o_sp_clk_en)
    else $error("Subdomain enable without its domain enable");

  // Gate bit open in the cycle before the domain pulse
  sequence seq_sp_gate_open;
    gate_q[cmds_pkg::CMDS_GATE_SP_LSB] ##1 o_sp_clk_en;
  endsequence

  AST_GATE_ON: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    seq_sp_gate_open |-> o_sp_sub_clk_en[0])
    else $error("Open subdomain missed its domain pulse");

endmodule

// ### tb/cmds_domain_model.sv
// Domain side model: counts clock enable pulses seen by each domain.
// Assumes enables are one-cycle pulses on i_clk.
`timescale 1ns/10ps
module cmds_domain_model (
  // Clock and clear
  input wire logic i_clk,
  input wire logic i_clr,
  // Enables: proc, sp, spmmu, tc, proc sub0, sp sub0, tc sub3
  input wire logic [6:0] i_en,
  // Pulse counts
  output logic [6:0][7:0] o_cnt
);
  always_ff @(posedge i_clk) begin
    for (int k = 0; k < 7; k++) begin
      o_cnt[k] <= i_clr ? 8'h00 : o_cnt[k] + {7'h00, i_en[k]};
    end
  end
endmodule

// ### tb/tb_top.sv
// Self-checking bench for the clock mode and divider selector.
// Assumes Wishbone ack comes, else the watchdog ends; PLL tick every 2 cycles, ref every 8.
`timescale 1ns/10ps
module tb_top;
  logic i_clk, i_rst_n, i_pll_tick, i_ref_tick, cyc, stb, we, clr;
  logic [7:0] adr, gen_q;
  logic [3:0] sel;
  logic [31:0] wdat, rd;
  logic o_wb_ack;
  logic [31:0] o_wb_dat;
  logic pe, se, me, te;
  logic [3:0] ps, ss, ts;
  logic [6:0][7:0] cnt;
  int bad_count, checked;
  // Mode, divider, expected proc/sp/mmu/tc pulses over 128 cycles
  logic [47:0] rows [6] = '{48'h00_00_40_40_40_40, 48'h00_ff_08_08_08_08,
    48'h02_e4_40_20_10_08, 48'h05_e4_10_10_10_10, 48'h06_96_10_20_20_10,
    48'h07_54_40_20_20_20};

  cmds_top cmds_top_i (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_pll_tick(i_pll_tick),
    .i_ref_tick(i_ref_tick), .i_wb_cyc(cyc), .i_wb_stb(stb), .i_wb_we(we),
    .i_wb_adr(adr), .i_wb_sel(sel), .i_wb_dat(wdat), .o_wb_ack(o_wb_ack),
    .o_wb_dat(o_wb_dat), .o_proc_clk_en(pe), .o_sp_clk_en(se), .o_spmmu_clk_en(me),
    .o_tc_clk_en(te), .o_proc_sub_clk_en(ps), .o_sp_sub_clk_en(ss),
    .o_tc_sub_clk_en(ts));
  cmds_domain_model cmds_domain_model_i (.i_clk(i_clk), .i_clr(clr),
    .i_en({ts[3], ss[0], ps[0], te, me, se, pe}), .o_cnt(cnt));

  initial begin
    i_clk = 1'b0;
    forever #5 i_clk = ~i_clk;
  end

  always @(posedge i_clk) begin
    gen_q <= gen_q + 8'h01;
    i_pll_tick <= gen_q[0];
    i_ref_tick <= (gen_q[2:0] == 3'h7);
  end

  task chk(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      bad_count++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task wb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
    @(posedge i_clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    sel <= s;
    do begin
      @(posedge i_clk);
    end while (o_wb_ack !== 1'b1);
    rd = o_wb_dat;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask

  task measure(input logic [55:0] exp);
    repeat (40) @(posedge i_clk);
    clr <= 1'b1;
    @(posedge i_clk);
    clr <= 1'b0;
    repeat (128) @(posedge i_clk);
    @(negedge i_clk);
    for (int k = 0; k < 7; k++) chk({24'h0, cnt[k]}, {24'h0, exp[k*8 +: 8]});
  endtask

  task final_report;
    if (bad_count == 0 && checked > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge i_clk);
    bad_count++;
    final_report;
  end

  initial begin
    logic [7:0] p, s, m, t;
    i_rst_n = 1'b0;
    {cyc, stb, we, clr} = 4'h0;
    {adr, sel, wdat, gen_q, i_pll_tick, i_ref_tick} = '0;
    repeat (10) @(posedge i_clk);
    i_rst_n <= 1'b1;
    wb(1'b0, cmds_pkg::CMDS_OFS_STATUS, 32'h0, 4'hf);
    chk(rd, 32'h0);
    wb(1'b0, cmds_pkg::CMDS_OFS_GATE, 32'h0, 4'hf);
    chk(rd, {20'h0, cmds_pkg::CMDS_GATE_RST});
    wb(1'b1, 8'h0c, 32'h5a, 4'hf);
    wb(1'b0, 8'h0c, 32'h0, 4'hf);
    chk(rd, 32'h0);
    measure({7{8'h40}});
    foreach (rows[i]) begin
      {p, s, m, t} = rows[i][31:0];
      wb(1'b1, cmds_pkg::CMDS_OFS_DIV, {24'h0, rows[i][39:32]}, 4'h1);
      wb(1'b1, cmds_pkg::CMDS_OFS_STATUS, {24'h0, rows[i][47:40]}, 4'h1);
      measure({t, s, p, t, m, s, p});
      wb(1'b0, cmds_pkg::CMDS_OFS_STATUS, 32'h0, 4'hf);
      chk(rd[5:0], {rows[i][42:40], rows[i][42:40]});
    end
    foreach (rows[i]) begin
      if (i < 3) begin
        wb(1'b1, cmds_pkg::CMDS_OFS_STATUS, {29'h0, i == 0 ? 3'h1 : i == 1 ? 3'h3 : 3'h4}, 4'h1);
        repeat (20) @(posedge i_clk);
        wb(1'b0, cmds_pkg::CMDS_OFS_STATUS, 32'h0, 4'hf);
        chk(rd, 32'h3f);
      end
    end
    wb(1'b1, cmds_pkg::CMDS_OFS_GATE, 32'h0f0, 4'h3);
    wb(1'b1, cmds_pkg::CMDS_OFS_DIV, 32'h0, 4'h1);
    wb(1'b1, cmds_pkg::CMDS_OFS_STATUS, 32'h0, 4'h1);
    measure({8'h00, 8'h40, 8'h00, {4{8'h40}}});
    // Mid-run reset after moving every register away from its default
    wb(1'b1, cmds_pkg::CMDS_OFS_STATUS, 32'h2, 4'h1);
    wb(1'b1, cmds_pkg::CMDS_OFS_DIV, 32'he4, 4'h1);
    i_rst_n <= 1'b0;
    repeat (3) @(posedge i_clk);
    i_rst_n <= 1'b1;
    wb(1'b0, cmds_pkg::CMDS_OFS_STATUS, 32'h0, 4'hf);
    chk(rd, 32'h0);
    wb(1'b0, cmds_pkg::CMDS_OFS_DIV, 32'h0, 4'hf);
    chk(rd, {24'h0, cmds_pkg::CMDS_DIV_RST});
    wb(1'b0, cmds_pkg::CMDS_OFS_GATE, 32'h0, 4'hf);
    chk(rd, {20'h0, cmds_pkg::CMDS_GATE_RST});
    measure({7{8'h40}});
    final_report;
  end
endmodule
